// ===== src/dsj_exec.sv
// execution of decrement, decrement-and-skip and jump instructions
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RQ1 - decrement puts file minus one in acc, or back in file if dest is set.
// RQ2 - plain decrement sets zero on an 8-bit zero result, else clears it.
// RQ3 - decrement-and-skip takes one off the file and changes no flag.
// RQ4 - decrement-and-skip sends its result to acc or file by the dest bit.
// RQ5 - a zero skip result turns the next instruction into a no-op.
// RQ6 - a skip cycle decodes in Q1, reads in Q2, works in Q3, writes in Q4.
// RQ7 - a jump loads the 11-bit immediate into counter bits 10:0, no flag.
// RQ8 - a jump takes counter bits 12:11 from upper jump latch bits 4:3.
// RQ9 - a jump lasts two cycles and the second is a no-op that only steps the counter on by one.
// RQ10 - jump immediates span zero through 2047, the whole field.
module dsj_exec (
  // clocking
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  // instruction fetch
  input wire logic [dsj_pkg::dsj_word_width-1:0] instr,
  input wire logic [7:0] upper_jump_latch,
  output logic [dsj_pkg::dsj_pc_width-1:0] program_counter,
  // data register file
  output logic [dsj_pkg::dsj_faddr_width-1:0] file_addr,
  output logic file_read,
  input wire logic [7:0] file_rdata,
  output logic file_write,
  output logic [7:0] file_wdata,
  // core state
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic squash,
  output dsj_pkg::dsj_phase_type phase
);
  import dsj_pkg::*;

  // ==========================================================
  // phase and decode
  logic cycle_end;
  dsj_phase u_phase (
    .clock(clock),
    .nrst(nrst),
    .enable(enable),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  logic is_dec, is_dsz, is_jmp, dest_file;
  logic [7:0] operand, result;
  logic [dsj_pc_width-1:0] next_pc;
  logic kill_next;

  assign is_dec = !squash && (instr[13:8] == dsj_decrement_op);
  assign is_dsz = !squash && (instr[13:8] == dsj_decrement_skip_zero_op);
  assign is_jmp = !squash && (instr[13:11] == dsj_jump_op);
  assign dest_file = instr[dsj_dest_bit];

  // ==========================================================
  // register access by quarter-phase
  always_ff @(posedge clock) begin
    if (!nrst) begin
      file_addr <= '0;
    end else if (enable && phase == dsj_q1) begin
      file_addr <= instr[dsj_faddr_width-1:0]; // RQ6
    end
  end

  assign file_read = enable && (phase == dsj_q2) && (is_dec || is_dsz); // RQ6

  always_ff @(posedge clock) begin
    if (!nrst) begin
      operand <= 8'h00;
    end else if (enable && phase == dsj_q2 && (is_dec || is_dsz)) begin
      operand <= file_rdata; // RQ6
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      result <= 8'h00;
    end else if (enable && phase == dsj_q3) begin
      result <= operand - 8'h01; // RQ1 RQ3 RQ6
    end
  end

  // ==========================================================
  // destination write in Q4
  assign file_write = enable && (phase == dsj_q4) && (is_dec || is_dsz)
    && dest_file; // RQ1 RQ4 RQ6
  assign file_wdata = result;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      accumulator <= dsj_acc_reset;
    end else if (enable && phase == dsj_q4 && (is_dec || is_dsz)
        && !dest_file) begin
      accumulator <= result; // RQ1 RQ4
    end
  end

  // only plain decrement touches zero; skip form leaves it alone
  always_ff @(posedge clock) begin
    if (!nrst) begin
      zero_flag <= 1'b0;
    end else if (enable && phase == dsj_q4 && is_dec) begin // RQ3 RQ7
      zero_flag <= (result == 8'h00); // RQ2
    end
  end

  // ==========================================================
  // program counter and second-cycle no-op
  always_comb begin
    next_pc = program_counter + 13'h0001;
    if (is_jmp) begin
      next_pc = {upper_jump_latch[dsj_latch_hi:dsj_latch_lo],
        instr[dsj_imm_width-1:0]}; // RQ7 RQ8 RQ10
    end
  end

  // a jump or a zero skip result kills whatever was fetched behind it
  assign kill_next = is_jmp || (is_dsz && result == 8'h00); // RQ5 RQ9

  always_ff @(posedge clock) begin
    if (!nrst) begin
      program_counter <= dsj_pc_reset;
    end else if (cycle_end) begin
      program_counter <= next_pc; // RQ7
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      squash <= 1'b0;
    end else if (cycle_end) begin
      squash <= kill_next; // RQ5 RQ9
    end
  end

  // ==========================================================
  // checks
  property p_dec_zero;
    @(posedge clock) disable iff (!nrst)
      (enable && phase == dsj_q4 && is_dec)
      |=> zero_flag == (file_wdata == 8'h00);
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("zero wrong"); // RQ2

  property p_dsz_keeps_zero;
    @(posedge clock) disable iff (!nrst)
      (enable && is_dsz) |=> $stable(zero_flag);
  endproperty
  a_dsz_keeps_zero: assert property (p_dsz_keeps_zero) // RQ3
    else $error("skip hit zero");

  property p_write_q4;
    @(posedge clock) disable iff (!nrst)
      file_write |-> phase == dsj_q4 && dest_file;
  endproperty
  a_write_q4: assert property (p_write_q4) // RQ6
    else $error("write outside Q4");

  property p_acc_dest;
    @(posedge clock) disable iff (!nrst)
      (enable && phase == dsj_q4 && (is_dec || is_dsz) && !dest_file)
      |=> accumulator == $past(result);
  endproperty
  a_acc_dest: assert property (p_acc_dest) // RQ4
    else $error("acc not loaded");

  property p_dec_value;
    @(posedge clock) disable iff (!nrst)
      (enable && phase == dsj_q2 && (is_dec || is_dsz)) ##1 enable [*1]
      |=> result == $past(operand) - 8'h01;
  endproperty
  a_dec_value: assert property (p_dec_value) // RQ1
    else $error("bad decrement");

  property p_jump_target;
    @(posedge clock) disable iff (!nrst)
      (cycle_end && is_jmp) |=>
      program_counter == {$past(upper_jump_latch[4:3]), $past(instr[10:0])};
  endproperty
  a_jump_target: assert property (p_jump_target) // RQ8
    else $error("bad jump pc");

  property p_jump_nop;
    @(posedge clock) disable iff (!nrst)
      (cycle_end && is_jmp) |=> squash ##0 !file_read [*1];
  endproperty
  a_jump_nop: assert property (p_jump_nop) // RQ9
    else $error("jump no-op missing");

  property p_skip_zero;
    @(posedge clock) disable iff (!nrst)
      (cycle_end && is_dsz) |=> squash == ($past(result) == 8'h00);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("skip wrong"); // RQ5

  property p_squash_quiet;
    @(posedge clock) disable iff (!nrst)
      squash |-> !file_write && !file_read;
  endproperty
  a_squash_quiet: assert property (p_squash_quiet) // RQ9
    else $error("no-op acted");

  // the squashed slot still moves the counter on by one
  property p_pc_step;
    @(posedge clock) disable iff (!nrst)
      (cycle_end && !is_jmp)
      |=> program_counter == $past(program_counter) + 13'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) // RQ9
    else $error("counter not stepped");

  property p_jump_keeps_zero;
    @(posedge clock) disable iff (!nrst)
      (enable && is_jmp) |=> $stable(zero_flag);
  endproperty
  a_jump_keeps_zero: assert property (p_jump_keeps_zero) // RQ7
    else $error("jump hit zero");

  property p_nop_keeps_acc;
    @(posedge clock) disable iff (!nrst)
      (cycle_end && squash) |=> $stable(accumulator) && $stable(zero_flag);
  endproperty
  a_nop_keeps_acc: assert property (p_nop_keeps_acc) // RQ5
    else $error("no-op changed state");

  property p_read_q2;
    @(posedge clock) disable iff (!nrst)
      file_read |-> phase == dsj_q2 && (is_dec || is_dsz);
  endproperty
  a_read_q2: assert property (p_read_q2) // RQ6
    else $error("read outside Q2");
endmodule // dsj_exec
`default_nettype wire

// ===== inc/dsj_pkg.sv
// shared constants for the decrement, skip and jump execution block
package dsj_pkg;
  localparam int dsj_word_width = 14;
  localparam int dsj_pc_width = 13;
  localparam int dsj_faddr_width = 7;
  localparam logic [5:0] dsj_decrement_op = 6'h03;
  localparam logic [5:0] dsj_decrement_skip_zero_op = 6'h0b;
  localparam logic [2:0] dsj_jump_op = 3'h5;
  localparam int dsj_dest_bit = 7;
  localparam int dsj_latch_lo = 3;
  localparam int dsj_latch_hi = 4;
  localparam int dsj_imm_width = 11;
  localparam logic [10:0] dsj_imm_max = 11'h7ff;
  localparam logic [1:0] dsj_q_reset = 2'h0;
  localparam logic [7:0] dsj_acc_reset = 8'h00;
  localparam logic [12:0] dsj_pc_reset = 13'h0000;
  typedef enum logic [1:0] {dsj_q1, dsj_q2, dsj_q3, dsj_q4} dsj_phase_type;
endpackage

// ===== src/dsj_phase.sv
// quarter-phase sequencer for one instruction cycle
`timescale 1ns/100ps
`default_nettype none
module dsj_phase (
  // clocking
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  // phase
  output dsj_pkg::dsj_phase_type phase,
  output logic cycle_end
);
  import dsj_pkg::*;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase <= dsj_q1;
    end else if (enable) begin
      case (phase)
        dsj_q1: phase <= dsj_q2;
        dsj_q2: phase <= dsj_q3;
        dsj_q3: phase <= dsj_q4;
        dsj_q4: phase <= dsj_q1;
        default: phase <= dsj_q1;
      endcase
    end
  end
  assign cycle_end = enable && (phase == dsj_q4);
endmodule // dsj_phase
`default_nettype wire

// ===== verification/dsj_file_model.sv
// data register file model facing the execution block
`timescale 1ns/100ps
`default_nettype none
module dsj_file_model (
  // clocking
  input wire logic clock,
  // register file port
  input wire logic [6:0] file_addr,
  input wire logic file_read,
  output logic [7:0] file_rdata,
  input wire logic file_write,
  input wire logic [7:0] file_wdata
);
  logic [7:0] mem [128];
  logic [7:0] last = 8'h00;
  // released data shows the inverse, so a late sample cannot match
  assign file_rdata = file_read ? mem[file_addr] : ~last;
  always @(posedge clock) begin
    if (file_read) last <= mem[file_addr];
    if (file_write) mem[file_addr] <= file_wdata;
  end
endmodule // dsj_file_model
`default_nettype wire

// ===== verification/dsj_exec_tb_top.sv
// self-checking bench for the decrement, skip and jump block
`timescale 1ns/100ps
`default_nettype none
module dsj_exec_tb_top;
  import dsj_pkg::*;
  logic clock = 0;
  logic nrst = 0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] latch = 8'h00;
  logic en = 1'b1;
  logic [12:0] pc;
  logic [6:0] fa;
  logic fr, fw, zero, squash;
  logic [7:0] frd, fwd, acc;
  dsj_phase_type phase;
  int n_errors = 0;
  int total_checks = 0;
  initial begin
    forever #4 clock = ~clock;
  end
  dsj_exec u_dsj_exec (.clock(clock), .nrst(nrst), .enable(en),
    .instr(instr), .upper_jump_latch(latch), .program_counter(pc),
    .file_addr(fa), .file_read(fr), .file_rdata(frd), .file_write(fw),
    .file_wdata(fwd), .accumulator(acc), .zero_flag(zero),
    .squash(squash), .phase(phase));
  dsj_file_model u_dsj_file_model (.clock(clock), .file_addr(fa),
    .file_read(fr), .file_rdata(frd), .file_write(fw), .file_wdata(fwd));
  task automatic chk(string n, logic [12:0] e, logic [12:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one instruction cycle from q1; strobes judged in the phase shown
  task automatic run(logic [13:0] w);
    int i;
    i = 0;
    while (phase !== dsj_q1 && i < 8) begin
      @(negedge clock);
      i++;
    end
    if (i == 8) begin
      chk("align", 1, 0);
      wrap_up();
    end
    instr = w;
    for (i = 0; i < 4; i++) begin
      if (fr === 1'b1) chk("rd_ph", dsj_q2, phase);
      if (fw === 1'b1) chk("wr_ph", dsj_q4, phase);
      @(negedge clock);
    end
  endtask
  task automatic t_dec();
    u_dsj_file_model.mem[5] = 8'h01;
    u_dsj_file_model.mem[6] = 8'h10;
    run(14'h0305);
    chk("acc", 13'h00, acc);
    chk("m5", 13'h01, u_dsj_file_model.mem[5]);
    chk("z", 13'h1, zero);
    run(14'h0386);
    chk("m6", 13'h0f, u_dsj_file_model.mem[6]);
    chk("z", 13'h0, zero);
    $display("test dec done");
  endtask
  task automatic t_skip();
    u_dsj_file_model.mem[7] = 8'h03;
    u_dsj_file_model.mem[8] = 8'h01;
    run(14'h0305);
    run(14'h0b87);
    chk("m7", 13'h02, u_dsj_file_model.mem[7]);
    chk("z", 13'h1, zero);
    chk("sq", 13'h0, squash);
    run(14'h0b07);
    chk("acc", 13'h01, acc);
    run(14'h0386);
    run(14'h0b08);
    chk("acc", 13'h00, acc);
    chk("z", 13'h0, zero);
    chk("sq", 13'h1, squash);
    run(14'h0386);
    chk("m6", 13'h0e, u_dsj_file_model.mem[6]);
    $display("test skip done");
  endtask
  task automatic t_jump();
    // raise zero first so a jump that touched it would show
    run(14'h0305);
    chk("z", 13'h1, zero);
    latch = 8'he8;
    run(14'h2fff);
    chk("pc", 13'h0fff, pc);
    chk("sq", 13'h1, squash);
    chk("z", 13'h1, zero);
    run(14'h0386);
    chk("m6", 13'h0e, u_dsj_file_model.mem[6]);
    chk("pc", 13'h1000, pc);
    latch = 8'h18;
    run(14'h2800);
    chk("pc", 13'h1800, pc);
    $display("test jump done");
  endtask
  // hold enable low across the end of a squashed cycle
  task automatic t_freeze();
    logic [12:0] held;
    instr = 14'h0386;
    repeat (3) @(negedge clock);
    held = pc;
    en = 1'b0;
    repeat (3) @(negedge clock);
    chk("fz_ph", dsj_q4, phase);
    chk("fz_pc", held, pc);
    chk("fz_sq", 13'h1, squash);
    en = 1'b1;
    @(negedge clock);
    chk("pc", 13'h1801, pc);
    chk("sq", 13'h0, squash);
    chk("m6", 13'h0e, u_dsj_file_model.mem[6]);
    run(14'h0386);
    chk("m6", 13'h0d, u_dsj_file_model.mem[6]);
    chk("z", 13'h0, zero);
    $display("test freeze done");
  endtask
  initial begin
    #200000;
    chk("timeout", 1, 0);
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge clock);
    nrst = 1;
    chk("pc0", 13'h0, pc);
    t_dec();
    t_skip();
    t_jump();
    t_freeze();
    wrap_up();
  end
endmodule // dsj_exec_tb_top
`default_nettype wire
